// ===== src/nvb_ctrl.sv
`timescale 1ns/100ps
`include "nvb_params.svh"

// Byte access controller between CPU I/O space and the data store.
module nvb_ctrl
  import nvb_pkg::*;
#(
  parameter int T_ERWR_RC = `NVB_T_ERWR_RC,
  parameter int T_ER_RC   = `NVB_T_ER_RC,
  parameter int T_WR_RC   = `NVB_T_WR_RC
)(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       prog_rst_n_i,
  input  wire logic [1:0] io_addr_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       upper_area_lock_fuse_i,
  input  wire logic       flash_selfprog_active_i,
  input  wire logic       global_irq_enable_i,
  input  wire logic       rc_tick_i,
  output logic      [7:0] io_rdata_o,
  output logic            cpu_stall_o,
  output logic            ready_irq_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam int CW = 17;
  logic [7:0]  nv_pointer_low_reg;
  logic        pointer_bit8_reg;
  logic [7:0]  nv_byte_value_reg;
  logic [1:0]  program_action_reg;
  logic        ready_irq_enable_reg;
  logic        master_write_arm_reg;
  logic [2:0]  arm_cnt_reg;
  logic        write_strobe_busy_reg;
  logic        read_strobe_reg;
  logic [2:0]  stall_cnt_reg;
  logic        rd_pending_reg;
  nvb_state_t  state_reg;
  logic [8:0]  nv_byte_pointer;
  logic [7:0]  arr_rdata;
  logic        ctrl_wr;
  logic        start_wr;
  logic        start_rd;
  logic        prog_done;
  logic        locked;
  logic [CW-1:0] ticks;
  logic [7:0]  prog_data_reg;
  logic        prog_start;

  assign nv_byte_pointer = {pointer_bit8_reg, nv_pointer_low_reg};
  assign ctrl_wr = io_wr_i && (io_addr_i == `NVB_OFS_CTRL);
  assign locked  = upper_area_lock_fuse_i && (nv_byte_pointer >= `NVB_LOCK_BASE);

  // Strobe only counts while armed, idle, not locked, no flash self-program.
  assign start_wr = ctrl_wr && io_wdata_i[`NVB_BIT_WR] && master_write_arm_reg
                    && !write_strobe_busy_reg && !flash_selfprog_active_i
                    && !locked;
  // Reads are refused while programming is running.
  assign start_rd = ctrl_wr && io_wdata_i[`NVB_BIT_RD] && !write_strobe_busy_reg;

  // A write only launches from idle and outside system reset; its data
  // byte is latched then, because system reset clears the data register.
  assign prog_start = start_wr && rst_n_i && (state_reg == NVB_IDLE);

  // Time of the selected action, in RC ticks.
  always_comb
  begin
    case (nvb_action_t'(program_action_reg))
      NVB_PM_ERASE_WRITE: ticks = CW'(T_ERWR_RC);
      NVB_PM_ERASE_ONLY:  ticks = CW'(T_ER_RC);
      NVB_PM_WRITE_ONLY:  ticks = CW'(T_WR_RC);
      default:            ticks = CW'(T_ERWR_RC);
    endcase
  end

  // --------------------------------------------------------------------
  // Pointer and data registers
  // --------------------------------------------------------------------
  // Pointer has no reset; software must load it before use.
  // Both halves are frozen while busy so the write target holds still.
  always_ff @(posedge clk_i)
  begin
    if (io_wr_i && !write_strobe_busy_reg)
    begin
      if (io_addr_i == `NVB_OFS_PTR_LO)
        nv_pointer_low_reg <= io_wdata_i;
      if (io_addr_i == `NVB_OFS_PTR_HI)
        pointer_bit8_reg <= io_wdata_i[0];
    end
  end

  // Data register takes CPU writes and captured read bytes.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      nv_byte_value_reg <= `NVB_DATA_RST;
    else if (rd_pending_reg)
      nv_byte_value_reg <= arr_rdata;
    else if (io_wr_i && io_addr_i == `NVB_OFS_DATA)
      nv_byte_value_reg <= io_wdata_i;
  end

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  // System reset of the action field is held off while a write is in progress; program reset is not.
  always_ff @(posedge clk_i or negedge prog_rst_n_i)
  begin
    if (!prog_rst_n_i)
      program_action_reg <= `NVB_PM_RST;
    else if (!rst_n_i && !write_strobe_busy_reg)
      program_action_reg <= `NVB_PM_RST;
    else if (rst_n_i && ctrl_wr && !write_strobe_busy_reg)
      program_action_reg <= io_wdata_i[`NVB_BIT_PM_HI:`NVB_BIT_PM_LO];
  end

  // Interrupt enable bit.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ready_irq_enable_reg <= 1'b0;
    else if (ctrl_wr)
      ready_irq_enable_reg <= io_wdata_i[`NVB_BIT_RIE];
  end

  // Arm bit times out; rewriting it while set does not extend it.
  // The count only restarts once the bit has dropped back to zero.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      master_write_arm_reg <= 1'b0;
      arm_cnt_reg          <= 3'h0;
    end
    else if (master_write_arm_reg)
    begin
      arm_cnt_reg <= arm_cnt_reg + 3'h1;
      if (arm_cnt_reg == `NVB_ARM_CYCLES - 3'h1)
        master_write_arm_reg <= 1'b0;
    end
    else if (ctrl_wr && io_wdata_i[`NVB_BIT_ARM])
    begin
      master_write_arm_reg <= 1'b1;
      arm_cnt_reg          <= 3'h0;
    end
  end

  // Busy flag, kept across system reset so a write completes.
  always_ff @(posedge clk_i or negedge prog_rst_n_i)
  begin
    if (!prog_rst_n_i)
    begin
      write_strobe_busy_reg <= 1'b0;
      state_reg             <= NVB_IDLE;
    end
    else
    begin
      case (state_reg)
        NVB_IDLE:
        begin
          if (prog_start)
          begin
            write_strobe_busy_reg <= 1'b1;
            state_reg             <= NVB_BUSY;
          end
        end
        NVB_BUSY:
        begin
          if (prog_done)
          begin
            write_strobe_busy_reg <= 1'b0;
            state_reg             <= NVB_IDLE;
          end
        end
        default:
          state_reg <= NVB_IDLE;
      endcase
    end
  end

  // Read strobe is visible for one cycle then clears itself.
  // A fresh strobe in the clearing cycle wins over the self-clear.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      read_strobe_reg <= 1'b0;
      rd_pending_reg  <= 1'b0;
    end
    else
    begin
      read_strobe_reg <= start_rd;
      rd_pending_reg  <= start_rd;
      if (rd_pending_reg && !start_rd)
        read_strobe_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Programming engine
  // --------------------------------------------------------------------
  // Byte to program, captured at the strobe and cleared only at power-on.
  // A private copy lets a write finish intact across a system reset, and
  // keeps a stray data register write from changing the byte in flight.
  always_ff @(posedge clk_i or negedge prog_rst_n_i)
  begin
    if (!prog_rst_n_i)
      prog_data_reg <= `NVB_DATA_RST;
    else if (prog_start)
      prog_data_reg <= nv_byte_value_reg;
  end

  // --------------------------------------------------------------------
  // Stall and interrupt
  // --------------------------------------------------------------------
  // Stall counter; holds the CPU four cycles on a read, two on a write.
  // A read and a write strobe together take the longer read stall.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stall_cnt_reg <= 3'h0;
      cpu_stall_o   <= 1'b0;
    end
    else if (start_rd)
    begin
      stall_cnt_reg <= `NVB_RD_STALL - 3'h1;
      cpu_stall_o   <= 1'b1;
    end
    else if (start_wr)
    begin
      stall_cnt_reg <= `NVB_WR_STALL - 3'h1;
      cpu_stall_o   <= 1'b1;
    end
    else if (stall_cnt_reg != 3'h0)
    begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
    end
    else
    begin
      cpu_stall_o <= 1'b0;
    end
  end

  // Level interrupt while idle; a busy flag clearing raises it.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ready_irq_o <= 1'b0;
    else
      ready_irq_o <= ready_irq_enable_reg && global_irq_enable_i
                     && !write_strobe_busy_reg && !start_wr;
  end

  // Register read mux, reserved bits zero.
  // A data read in the fetch cycle bypasses to the array output.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      io_rdata_o <= 8'h00;
    else if (io_rd_i)
    begin
      case (io_addr_i)
        `NVB_OFS_CTRL:   io_rdata_o <= {2'b00, program_action_reg, ready_irq_enable_reg,
                                        master_write_arm_reg, write_strobe_busy_reg,
                                        read_strobe_reg};
        `NVB_OFS_DATA:   io_rdata_o <= rd_pending_reg ? arr_rdata : nv_byte_value_reg;
        `NVB_OFS_PTR_LO: io_rdata_o <= nv_pointer_low_reg;
        `NVB_OFS_PTR_HI: io_rdata_o <= {7'h00, pointer_bit8_reg};
        default:         io_rdata_o <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  nvb_array #(.DEPTH(`NVB_DEPTH)) u_array (
    .clk_i    (clk_i),
    .addr_i   (nv_byte_pointer),
    .rd_i     (start_rd),
    .prog_i   (prog_done),
    .action_i (program_action_reg),
    .wdata_i  (prog_data_reg),
    .rdata_o  (arr_rdata)
  );

  // The timer restarts only from idle, so one write is timed at a time.
  nvb_timer #(.CW(CW)) u_timer (
    .clk_i     (clk_i),
    .rst_n_i   (prog_rst_n_i),
    .start_i   (prog_start),
    .ticks_i   (ticks),
    .rc_tick_i (rc_tick_i),
    .done_o    (prog_done)
  );

endmodule : nvb_ctrl

// ===== src/nvb_params.svh
// Notes on behaviour
// - 320 single-byte locations in own space.
// - Lock fuse makes bytes above 0x0FF read-only.
// - Nine-bit pointer, upper seven bits read zero.
// - Data register feeds writes, receives reads.
// - Action field picks erase/write type and time.
// - Action field frozen while busy; reset clears.
// - Ready interrupt level while idle and enabled.
// - Arm bit self-clears four cycles after set.
// - Strobe starts programming only while armed.
// - Busy stays set until programming time ends.
// - No programming during flash self-programming.
// - Read strobe fetches byte for next instruction.
// - Read stalls the CPU four cycles.
// - Write start stalls the CPU two cycles.
// - Busy refuses reads and pointer changes.
// - Programming timed on RC oscillator ticks.
// - Erase and write lasts 67584 RC oscillator cycles.
// - System reset does not abort a running write.
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (I/O space indices)
// ----------------------------------------------------------------------
`define NVB_OFS_CTRL     2'h0
`define NVB_OFS_DATA     2'h1
`define NVB_OFS_PTR_LO   2'h2
`define NVB_OFS_PTR_HI   2'h3

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define NVB_BIT_RD       0
`define NVB_BIT_WR       1
`define NVB_BIT_ARM      2
`define NVB_BIT_RIE      3
`define NVB_BIT_PM_LO    4
`define NVB_BIT_PM_HI    5

// ----------------------------------------------------------------------
// Sizes, reset values and timing
// ----------------------------------------------------------------------
`define NVB_DEPTH        320
`define NVB_LOCK_BASE    9'h100
`define NVB_DATA_RST     8'h00
`define NVB_PM_RST       2'h0
`define NVB_ARM_CYCLES   3'h4
`define NVB_RD_STALL     3'h4
`define NVB_WR_STALL     3'h2
`define NVB_T_ERWR_RC    67584
`define NVB_T_ER_RC      35782
`define NVB_T_WR_RC      35782

`endif

// ===== src/nvb_pkg.sv
package nvb_pkg;
  typedef enum logic [1:0] {
    NVB_PM_ERASE_WRITE,
    NVB_PM_ERASE_ONLY,
    NVB_PM_WRITE_ONLY,
    NVB_PM_RESERVED
  } nvb_action_t;
  typedef enum logic [1:0] {NVB_IDLE, NVB_BUSY} nvb_state_t;
endpackage : nvb_pkg

// ===== src/nvb_array.sv
`timescale 1ns/100ps
`include "nvb_params.svh"

// Storage array with registered read and one-cycle byte program port.
module nvb_array
  import nvb_pkg::*;
#(
  parameter int DEPTH = `NVB_DEPTH
)(
  input  wire logic       clk_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       prog_i,
  input  wire logic [1:0] action_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);

  // --------------------------------------------------------------------
  // Cells
  // --------------------------------------------------------------------
  logic [7:0] mem [DEPTH];
  logic       in_range;

  // Out-of-range addresses neither program nor read real cells.
  assign in_range = (32'(addr_i) < DEPTH);

  // Erase leaves all ones; write only can clear bits, never set them.
  always_ff @(posedge clk_i)
  begin
    if (prog_i && in_range)
    begin
      case (nvb_action_t'(action_i))
        NVB_PM_ERASE_WRITE: mem[addr_i] <= wdata_i;
        NVB_PM_ERASE_ONLY:  mem[addr_i] <= 8'hFF;
        NVB_PM_WRITE_ONLY:  mem[addr_i] <= mem[addr_i] & wdata_i;
        default:            mem[addr_i] <= mem[addr_i];
      endcase
    end
  end

  // Read data; unmapped locations return all ones like erased cells.
  always_ff @(posedge clk_i)
  begin
    if (rd_i)
    begin
      rdata_o <= in_range ? mem[addr_i] : 8'hFF;
    end
  end

endmodule : nvb_array

// ===== src/nvb_timer.sv
`timescale 1ns/100ps
`include "nvb_params.svh"

// Programming timer counting RC oscillator ticks, not CPU clocks.
module nvb_timer
#(
  parameter int CW = 17
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic [CW-1:0] ticks_i,
  input  wire logic          rc_tick_i,
  output logic               done_o
);

  logic [CW-1:0] cnt_reg;
  logic          run_reg;

  // Counter loaded at start, decremented on each RC tick.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o  <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        cnt_reg <= ticks_i;
        run_reg <= 1'b1;
      end
      else if (run_reg && rc_tick_i)
      begin
        if (cnt_reg <= CW'(1))
        begin
          run_reg <= 1'b0;
          done_o  <= 1'b1;
        end
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

endmodule : nvb_timer

// ===== tb/nvb_ctrl_chk.sv
`timescale 1ns/100ps
`include "nvb_params.svh"

// ----------------------------------------
// Port checker for the byte controller
// ----------------------------------------
module nvb_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [1:0] io_addr_i,
  input wire logic       io_wr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic       upper_area_lock_fuse_i,
  input wire logic       flash_selfprog_active_i,
  input wire logic       global_irq_enable_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic       cpu_stall_o,
  input wire logic       ready_irq_o
);
  logic       ctl_wr;
  logic [2:0] arm_age_reg;

  // A write to the control register, where both strobes live.
  assign ctl_wr = io_wr_i && (io_addr_i == `NVB_OFS_CTRL);

  // Ages the last arm write; zero means the arm window has surely closed.
  // A rewrite late in the window restarts it, since the bit may be gone.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      arm_age_reg <= 3'h0;
    else if (ctl_wr && io_wdata_i[2] && arm_age_reg < 3'h3)
      arm_age_reg <= 3'h6;
    else if (arm_age_reg != 3'h0)
      arm_age_reg <= arm_age_reg - 3'h1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  read_stall_a : assert property (
    ctl_wr && io_wdata_i[1:0] == 2'b01 && ready_irq_o && !cpu_stall_o
    |=> cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall length wrong");
  write_stall_a : assert property (
    ctl_wr && io_wdata_i[2:0] == 3'b010 && arm_age_reg >= 3'h4 && ready_irq_o
    && !flash_selfprog_active_i && !upper_area_lock_fuse_i && !cpu_stall_o
    |=> cpu_stall_o [*2] ##1 !cpu_stall_o) else $error("write stall length wrong");
  unarmed_strobe_a : assert property (
    ctl_wr && io_wdata_i[2:0] == 3'b010 && arm_age_reg == 3'h0 && !cpu_stall_o
    |=> !cpu_stall_o) else $error("unarmed strobe started a write");
  selfprog_block_a : assert property (
    ctl_wr && io_wdata_i[1:0] == 2'b10 && flash_selfprog_active_i && !cpu_stall_o
    |=> !cpu_stall_o) else $error("write started during self programming");
  stall_cause_a : assert property (
    $rose(cpu_stall_o) |-> $past(ctl_wr) && $past(io_wdata_i[1:0]) != 2'b00)
    else $error("stall without strobe");
  stall_span_a : assert property (
    $rose(cpu_stall_o) |-> cpu_stall_o [*2] ##1
    (!cpu_stall_o or (cpu_stall_o [*2] ##1 !cpu_stall_o)))
    else $error("stall neither two nor four cycles");
  irq_gate_a : assert property (
    ready_irq_o |-> $past(global_irq_enable_i)) else $error("irq without global enable");
  irq_busy_a : assert property (
    $rose(cpu_stall_o) && $past(io_wdata_i[1:0]) == 2'b10 |=> !ready_irq_o [*2])
    else $error("irq high while busy");
  rdata_hold_a : assert property (
    !io_rd_i |=> $stable(io_rdata_o)) else $error("read data moved without read");
endmodule : nvb_ctrl_chk

bind nvb_ctrl nvb_ctrl_chk chk (
  .clk_i                   (clk_i),
  .rst_n_i                 (rst_n_i),
  .io_addr_i               (io_addr_i),
  .io_wr_i                 (io_wr_i),
  .io_rd_i                 (io_rd_i),
  .io_wdata_i              (io_wdata_i),
  .upper_area_lock_fuse_i  (upper_area_lock_fuse_i),
  .flash_selfprog_active_i (flash_selfprog_active_i),
  .global_irq_enable_i     (global_irq_enable_i),
  .io_rdata_o              (io_rdata_o),
  .cpu_stall_o             (cpu_stall_o),
  .ready_irq_o             (ready_irq_o)
);

// ===== tb/nvb_cpu_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// CPU side: one I/O access per request
// ----------------------------------------
module nvb_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic       we_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] data_i,
  input  wire logic       stall_i,
  output logic            ack_o,
  output logic            io_wr_o,
  output logic            io_rd_o,
  output logic      [1:0] io_addr_o,
  output logic      [7:0] io_wdata_o
);
  // A halted CPU issues nothing; idle buses toggle so stale data is never valid.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o      <= 1'b0;
      io_wr_o    <= 1'b0;
      io_rd_o    <= 1'b0;
      io_addr_o  <= 2'h0;
      io_wdata_o <= 8'h00;
    end
    else if (req_i && !ack_o && !stall_i)
    begin
      ack_o      <= 1'b1;
      io_wr_o    <= we_i;
      io_rd_o    <= !we_i;
      io_addr_o  <= addr_i;
      io_wdata_o <= data_i;
    end
    else
    begin
      ack_o      <= 1'b0;
      io_wr_o    <= 1'b0;
      io_rd_o    <= 1'b0;
      io_addr_o  <= ~io_addr_o;
      io_wdata_o <= ~io_wdata_o;
    end
  end
endmodule : nvb_cpu_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "nvb_params.svh"

module testbench;
  logic        clk_i, rst_n_i, prog_rst_n_i, fuse, selfprog, gie;
  logic        rc_tick = 1'b0;
  logic        req, we, ack, io_wr, io_rd, stall, irq;
  logic [1:0]  adr, io_addr, act;
  logic [7:0]  dat, io_wdata, rdata, rd, d;
  logic [8:0]  p;
  logic [31:0] seed;
  logic [7:0]  mem [0:319];
  int          bad_count, total_checks;

  nvb_ctrl #(.T_ERWR_RC(30), .T_ER_RC(16), .T_WR_RC(16)) uut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .prog_rst_n_i(prog_rst_n_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .upper_area_lock_fuse_i(fuse),
    .flash_selfprog_active_i(selfprog), .global_irq_enable_i(gie), .rc_tick_i(rc_tick),
    .io_rdata_o(rdata), .cpu_stall_o(stall), .ready_irq_o(irq));
  nvb_cpu_model cpu (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .we_i(we),
    .addr_i(adr), .data_i(dat), .stall_i(stall), .ack_o(ack), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_addr_o(io_addr), .io_wdata_o(io_wdata));

  // Clock, and an RC tick every second cycle so programming spans many clocks.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) rc_tick <= ~rc_tick;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Stored byte after an action: erase sets all ones, write only clears bits.
  function automatic logic [7:0] after(input logic [7:0] old, nw, input logic [1:0] a);
    case (a)
      2'b00: return nw;
      2'b01: return 8'hFF;
      2'b10: return old & nw;
      default: return old;
    endcase
  endfunction : after

  task automatic check(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // One CPU access; read data is taken the edge after the access completes.
  task automatic io(input logic w, input logic [1:0] a, input logic [7:0] v);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    req <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      results();
    end
    @(posedge clk_i);
    rd = rdata;
  endtask : io

  task automatic poll();
    int n;
    n = 0;
    do
    begin
      io(1'b0, `NVB_OFS_CTRL, 8'h00);
      n++;
    end
    while (rd[1] !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      bad_count++;
      results();
    end
  endtask : poll

  task automatic wr_byte(input logic [8:0] pa, input logic [7:0] v, input logic [1:0] a);
    io(1'b1, `NVB_OFS_PTR_HI, {7'h00, pa[8]});
    io(1'b1, `NVB_OFS_PTR_LO, pa[7:0]);
    io(1'b1, `NVB_OFS_DATA, v);
    io(1'b1, `NVB_OFS_CTRL, {2'b00, a, 4'hC});
    io(1'b1, `NVB_OFS_CTRL, {2'b00, a, 4'hA});
  endtask : wr_byte

  task automatic rd_byte(input logic [8:0] pa);
    io(1'b1, `NVB_OFS_PTR_HI, {7'h00, pa[8]});
    io(1'b1, `NVB_OFS_PTR_LO, pa[7:0]);
    io(1'b1, `NVB_OFS_CTRL, 8'h09);
    io(1'b0, `NVB_OFS_DATA, 8'h00);
  endtask : rd_byte

  // Main sequence.
  initial
  begin
    {rst_n_i, prog_rst_n_i, req, we, fuse, selfprog, adr, dat} = '0;
    gie = 1'b1;
    seed = 32'd30;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    prog_rst_n_i <= 1'b1;
    @(posedge clk_i);
    io(1'b0, `NVB_OFS_CTRL, 8'h00);
    check(rd, 8'h00);
    io(1'b0, `NVB_OFS_DATA, 8'h00);
    check(rd, `NVB_DATA_RST);
    io(1'b1, `NVB_OFS_PTR_HI, 8'hFF);
    io(1'b0, `NVB_OFS_PTR_HI, 8'h00);
    check(rd, 8'h01);
    io(1'b1, `NVB_OFS_CTRL, 8'h08);
    @(posedge clk_i);
    check({7'h00, irq}, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      p = (i == 0) ? 9'h000 : (i == 1) ? 9'h13F : (i == 2) ? 9'h100 : {1'b0, seed[7:0]};
      for (int a = 0; a < 4; a++)
      begin
        act = {a[0], a[1]};
        seed = xs(seed);
        d = seed[7:0];
        wr_byte(p, d, act);
        io(1'b0, `NVB_OFS_CTRL, 8'h00);
        check({7'h00, rd[1]}, 8'h01);
        check({7'h00, irq}, 8'h00);
        io(1'b1, `NVB_OFS_CTRL, 8'h38);
        io(1'b1, `NVB_OFS_PTR_LO, ~p[7:0]);
        io(1'b1, `NVB_OFS_CTRL, 8'h09);
        io(1'b0, `NVB_OFS_CTRL, 8'h00);
        check({6'h00, rd[5:4]}, {6'h00, act});
        check({7'h00, rd[0]}, 8'h00);
        poll();
        io(1'b0, `NVB_OFS_PTR_LO, 8'h00);
        check(rd, p[7:0]);
        mem[p] = after(mem[p], d, act);
        rd_byte(p);
        check(rd, mem[p]);
      end
    end
    $display("program actions test done");
    fuse <= 1'b1;
    wr_byte(9'h100, 8'h5A, 2'b00);
    io(1'b0, `NVB_OFS_CTRL, 8'h00);
    check({7'h00, rd[1]}, 8'h00);
    rd_byte(9'h100);
    check(rd, mem[9'h100]);
    fuse <= 1'b0;
    io(1'b1, `NVB_OFS_CTRL, 8'h0C);
    repeat (6) @(posedge clk_i);
    io(1'b1, `NVB_OFS_CTRL, 8'h0A);
    io(1'b0, `NVB_OFS_CTRL, 8'h00);
    check({6'h00, rd[2:1]}, 8'h00);
    selfprog <= 1'b1;
    wr_byte(9'h010, 8'h33, 2'b00);
    io(1'b0, `NVB_OFS_CTRL, 8'h00);
    check({7'h00, rd[1]}, 8'h00);
    selfprog <= 1'b0;
    rd_byte(9'h140);
    check(rd, 8'hFF);
    $display("refusal test done");
    seed = xs(seed);
    mem[9'h0AB] = seed[7:0];
    wr_byte(9'h0AB, seed[7:0], 2'b00);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    io(1'b0, `NVB_OFS_CTRL, 8'h00);
    check({7'h00, rd[1]}, 8'h01);
    poll();
    rd_byte(9'h0AB);
    check(rd, mem[9'h0AB]);
    gie <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({7'h00, irq}, 8'h00);
    $display("reset during write test done");
    results();
  end
endmodule : testbench
